// ---- ssp_pkg.sv ----
// Shared constants, types and carriers of the sync serial port slave
// What this block does
// R1: SPI shifts eight bits, MSB out first, new LSB in at once.
// R2: Outgoing data changes on the chosen edge, incoming sampled on the other.
// R3: Master makes the clock; both ends share the same idle polarity.
// R4: After eight bits registers have swapped; reload and repeat while data remains.
// R5: With no data left the master stops the clock and deselects.
// R6: Master gives each slave its own select, at most one active.
// R7: Unselected slave ignores clock and data and leaves its output undriven.
// R8: I2C start sets start-seen; interrupt flag only if start interrupts enabled.
// R9: Matching high address byte, write: set update-address, acknowledge, set interrupt.
// R10: Reading the receive buffer returns the byte and clears buffer-full; the block keeps it set while the FIFO holds another byte.
// R11: After the high address byte hold clock low until address rewritten.
// R12: Slave address writes are refused during the acknowledge of a byte.
// R13: Low address mismatch sets interrupt and update-address; no buffer-full, release untouched.
// R14: After low address match the high address must be restored before data.
// R15: Each data byte is acknowledged on the ninth clock, then interrupt set.
// R16: With stretch enabled each byte clears clock-release and holds the clock.
// R17: Acknowledge, interrupt, stretch, read, release repeat per byte until stop.
// R18: Address or data hold enables behave as the plain modes plus address reload; code ignores addressHoldEnable, treats dataHoldEnable as stretchEnable.
// R19: Buffer-full is set when an address or data byte enters the buffer.
package ssp_pkg;

  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] TX_RESET = 8'h00;

  typedef enum logic [3:0] {
    I2C_IDLE = 4'b0001,
    I2C_BYTE = 4'b0010,
    I2C_ACK = 4'b0100,
    I2C_IGNORE = 4'b1000
  } ssp_i2c_state_e;

  typedef enum logic [2:0] {
    PHASE_HIGH = 3'b001,
    PHASE_LOW = 3'b010,
    PHASE_DATA = 3'b100
  } ssp_phase_e;

  typedef struct packed {
    logic i2cMode;
    logic idleHigh;
    logic launchOnIdle;
    logic startIrqEnable;
    logic stretchEnable;
    logic addressHoldEnable;
    logic dataHoldEnable;
  } ssp_ctrl_s;

  typedef struct packed {
    logic portInterruptFlag;
    logic startSeen;
    logic stopSeen;
    logic updateAddressFlag;
    logic clockReleaseBit;
    logic overflow;
  } ssp_status_s;

  localparam ssp_status_s STATUS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

  typedef struct packed {
    logic sck;
    logic selectN;
    logic sdi;
    logic scl;
    logic sda;
  } ssp_pins_s;

  localparam ssp_pins_s PINS_RESET = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

endpackage

// ---- ssp_fifo.sv ----
// Small receive FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic doWrite, doRead;

  // Extra pointer bit tells full from empty
  always_comb begin
    inReady = (wrPtr_reg[PW] == rdPtr_reg[PW]) || (wrPtr_reg[PW-1:0] != rdPtr_reg[PW-1:0]);
    outValid = wrPtr_reg != rdPtr_reg;
    outData = mem[rdPtr_reg[PW-1:0]];
    doWrite = clkEn && inValid && inReady;
    doRead = clkEn && outValid && outReady;
    wrPtr_next = doWrite ? wrPtr_reg + (PW+1)'(1) : wrPtr_reg;
    rdPtr_next = doRead ? rdPtr_reg + (PW+1)'(1) : rdPtr_reg;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge mclk) begin
    if (doWrite) begin
      mem[wrPtr_reg[PW-1:0]] <= inData;
    end
  end
endmodule // ssp_fifo
`default_nettype wire

// ---- ssp_slave_top.sv ----
// SPI slave and 10-bit I2C slave receiver of the sync serial port
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_top
  import ssp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire ssp_ctrl_s ctrl,
  input wire logic serialClockPin,
  input wire logic slaveSelectPin_n,
  input wire logic serialInPin,
  output logic serialOutPin,
  output logic serialOutPinOe,
  input wire logic serialClockLineIn,
  output logic serialClockLineOut,
  output logic serialClockLineOe,
  input wire logic serialDataLineIn,
  output logic serialDataLineOut,
  output logic serialDataLineOe,
  input wire logic [7:0] txData,
  input wire logic txLoad,
  input wire logic [7:0] addrWriteData,
  input wire logic addrWrite,
  input wire logic clockReleaseSet,
  input wire logic irqClear,
  input wire logic rxRead,
  output logic [7:0] rxData,
  output logic bufferFullFlag,
  output logic [7:0] slaveAddress,
  output ssp_status_s status
);

  // Pin synchronisers: three stages, a change counts once stages two and three agree
  ssp_pins_s pinRaw, sync1_reg, sync2_reg, sync3_reg;
  ssp_pins_s pinF_reg, pinF_next, pinP_reg;

  always_comb begin
    pinRaw = '{serialClockPin, slaveSelectPin_n, serialInPin,
               serialClockLineIn, serialDataLineIn};
    pinF_next = ssp_pins_s'((~(sync2_reg ^ sync3_reg) & sync3_reg)
                          | ((sync2_reg ^ sync3_reg) & pinF_reg));
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= PINS_RESET;
      sync2_reg <= PINS_RESET;
      sync3_reg <= PINS_RESET;
      pinF_reg <= PINS_RESET;
      pinP_reg <= PINS_RESET;
    end else if (clkEn) begin
      sync1_reg <= pinRaw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pinF_reg <= pinF_next;
      pinP_reg <= pinF_reg;
    end
  end

  logic sckRise, sckFall, toActive, toIdle, launchEdge, captureEdge, selected;
  logic sclRise, sclFall, startCond, stopCond;

  always_comb begin
    sckRise = pinF_reg.sck && !pinP_reg.sck;
    sckFall = !pinF_reg.sck && pinP_reg.sck;
    toActive = ctrl.idleHigh ? sckFall : sckRise; // R3
    toIdle = ctrl.idleHigh ? sckRise : sckFall;
    launchEdge = ctrl.launchOnIdle ? toIdle : toActive; // R2
    captureEdge = ctrl.launchOnIdle ? toActive : toIdle; // R2
    selected = !pinF_reg.selectN && !ctrl.i2cMode;
    sclRise = pinF_reg.scl && !pinP_reg.scl;
    sclFall = !pinF_reg.scl && pinP_reg.scl;
    startCond = pinF_reg.scl && pinP_reg.scl && pinP_reg.sda && !pinF_reg.sda;
    stopCond = pinF_reg.scl && pinP_reg.scl && !pinP_reg.sda && pinF_reg.sda;
  end

  // Receive path: FIFO then one output register that software reads
  logic pushValid, pushReady, popValid, popReady;
  logic [7:0] pushData, popData;

  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popData)
  );

  // SPI shift engine state
  logic [7:0] spiShift_reg, spiShift_next, txHold_reg, txHold_next;
  logic [3:0] spiCnt_reg, spiCnt_next;
  logic spiPending_reg, spiPending_next, spiBit_reg, spiBit_next;
  logic spiOe_reg, spiOe_next, spiPush;
  logic [7:0] spiByte;

  // I2C receive engine state
  ssp_i2c_state_e i2cState_reg, i2cState_next;
  ssp_phase_e phase_reg, phase_next;
  logic [7:0] i2cShift_reg, i2cShift_next, addr_reg, addr_next;
  logic [3:0] i2cCnt_reg, i2cCnt_next;
  logic ackOe_reg, ackOe_next, sclHold_reg, sclHold_next, i2cPush;
  ssp_status_s status_reg, status_next;

  // Output register of the receive buffer
  logic [7:0] rxData_reg, rxData_next;
  logic rxValid_reg, rxValid_next;

  always_comb begin
    spiShift_next = spiShift_reg;
    txHold_next = txHold_reg;
    spiCnt_next = spiCnt_reg;
    spiPending_next = spiPending_reg;
    spiBit_next = spiBit_reg;
    spiOe_next = selected; // R7
    spiPush = 1'b0;
    spiByte = {spiShift_reg[6:0], pinF_reg.sdi};
    i2cState_next = i2cState_reg;
    phase_next = phase_reg;
    i2cShift_next = i2cShift_reg;
    i2cCnt_next = i2cCnt_reg;
    addr_next = addr_reg;
    ackOe_next = ackOe_reg;
    i2cPush = 1'b0;
    status_next = status_reg;

    // Software actions first so that hardware events in the same cycle win
    if (irqClear) begin
      status_next.portInterruptFlag = 1'b0;
      status_next.overflow = 1'b0;
    end
    if (clockReleaseSet) begin
      status_next.clockReleaseBit = 1'b1; // R16
    end
    if (addrWrite && i2cState_reg != I2C_ACK) begin // R12
      addr_next = addrWriteData;
      status_next.updateAddressFlag = 1'b0;
      status_next.clockReleaseBit = 1'b1; // R11
    end
    if (txLoad) begin
      txHold_next = txData;
    end

    // SPI: unselected means idle, counters cleared, output undriven
    if (!selected) begin // R7
      spiCnt_next = CNT_ZERO; // R5
      spiPending_next = 1'b0;
      spiShift_next = txLoad ? txData : txHold_reg;
    end else begin
      if (txLoad && spiCnt_reg == CNT_ZERO && !spiPending_reg) begin
        spiShift_next = txData;
      end
      if (captureEdge) begin
        if (spiCnt_reg == BIT_LAST) begin // R4
          spiPush = 1'b1;
          spiShift_next = txLoad ? txData : txHold_reg; // R4
          spiCnt_next = CNT_ZERO;
          spiPending_next = 1'b0;
          status_next.portInterruptFlag = 1'b1;
          if (!pushReady) begin
            status_next.overflow = 1'b1;
          end
        end else begin
          spiBit_next = pinF_reg.sdi; // R1
          spiPending_next = 1'b1;
          spiCnt_next = spiCnt_reg + 4'h1;
        end
      end else if (launchEdge && spiPending_reg) begin
        spiShift_next = {spiShift_reg[6:0], spiBit_reg}; // R1
        spiPending_next = 1'b0;
      end
    end

    // I2C receive sequence
    if (!ctrl.i2cMode) begin
      i2cState_next = I2C_IDLE;
      ackOe_next = 1'b0;
    end else if (startCond) begin
      status_next.startSeen = 1'b1; // R8
      status_next.stopSeen = 1'b0;
      if (ctrl.startIrqEnable) begin
        status_next.portInterruptFlag = 1'b1; // R8
      end
      i2cState_next = I2C_BYTE;
      phase_next = PHASE_HIGH;
      i2cCnt_next = CNT_ZERO;
      ackOe_next = 1'b0;
    end else if (stopCond) begin
      status_next.startSeen = 1'b0; // R17
      status_next.stopSeen = 1'b1;
      i2cState_next = I2C_IDLE;
      ackOe_next = 1'b0;
    end else begin
      unique case (i2cState_reg)
        I2C_IDLE, I2C_IGNORE: begin
          ackOe_next = 1'b0;
        end
        I2C_BYTE: begin
          if (sclRise && i2cCnt_reg != BYTE_DONE) begin
            i2cShift_next = {i2cShift_reg[6:0], pinF_reg.sda};
            i2cCnt_next = i2cCnt_reg + 4'h1;
          end else if (i2cCnt_reg == BYTE_DONE && !pinF_reg.scl && pushReady) begin
            unique case (phase_reg)
              PHASE_HIGH: begin
                if (i2cShift_reg[7:3] == TEN_BIT_PREFIX
                    && i2cShift_reg[7:1] == addr_reg[7:1] && !i2cShift_reg[0]) begin
                  status_next.updateAddressFlag = 1'b1; // R9
                  status_next.clockReleaseBit = 1'b0; // R11
                  i2cPush = 1'b1; // R19
                  ackOe_next = 1'b1; // R9
                  phase_next = PHASE_LOW;
                  i2cState_next = I2C_ACK;
                end else begin
                  i2cState_next = I2C_IGNORE;
                end
              end
              PHASE_LOW: begin
                status_next.updateAddressFlag = 1'b1; // R13
                if (i2cShift_reg == addr_reg) begin
                  // Hold until the high byte is put back
                  status_next.clockReleaseBit = 1'b0; // R14
                  i2cPush = 1'b1; // R19
                  ackOe_next = 1'b1;
                  phase_next = PHASE_DATA;
                  i2cState_next = I2C_ACK;
                end else begin
                  status_next.portInterruptFlag = 1'b1; // R13
                  i2cState_next = I2C_IGNORE;
                end
              end
              PHASE_DATA: begin
                i2cPush = 1'b1; // R19
                ackOe_next = 1'b1; // R15
                if (ctrl.stretchEnable || ctrl.dataHoldEnable) begin // R18
                  status_next.clockReleaseBit = 1'b0; // R16
                end
                i2cState_next = I2C_ACK;
              end
              default: begin
                i2cState_next = I2C_IGNORE;
              end
            endcase
          end
        end
        I2C_ACK: begin
          // Acknowledge stands for the whole ninth pulse
          if (sclFall) begin
            ackOe_next = 1'b0;
            status_next.portInterruptFlag = 1'b1; // R15
            i2cCnt_next = CNT_ZERO;
            i2cState_next = I2C_BYTE; // R17
          end
        end
        default: begin
          i2cState_next = I2C_IDLE;
          ackOe_next = 1'b0;
        end
      endcase
    end

    // Stretch only grabs a low clock so the master's high time is never cut short
    sclHold_next = ctrl.i2cMode && i2cState_reg == I2C_BYTE
                   && (!pinF_reg.scl || sclHold_reg)
                   && ((i2cCnt_reg == CNT_ZERO && !status_next.clockReleaseBit) // R11 R16
                       || (i2cCnt_reg == BYTE_DONE && !pushReady));
    if (startCond || stopCond) begin
      sclHold_next = 1'b0;
    end

    pushValid = spiPush || i2cPush;
    pushData = ctrl.i2cMode ? i2cShift_reg : spiByte;

    popReady = !rxValid_reg || rxRead;
    rxData_next = rxData_reg;
    rxValid_next = rxValid_reg;
    if (popReady && popValid) begin
      rxData_next = popData;
      rxValid_next = 1'b1; // R19
    end else if (rxRead) begin
      rxValid_next = 1'b0; // R10
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      spiShift_reg <= TX_RESET;
      txHold_reg <= TX_RESET;
      spiCnt_reg <= CNT_ZERO;
      spiPending_reg <= 1'b0;
      spiBit_reg <= 1'b0;
      spiOe_reg <= 1'b0;
      i2cState_reg <= I2C_IDLE;
      phase_reg <= PHASE_HIGH;
      i2cShift_reg <= TX_RESET;
      i2cCnt_reg <= CNT_ZERO;
      addr_reg <= ADDR_RESET;
      ackOe_reg <= 1'b0;
      sclHold_reg <= 1'b0;
      status_reg <= STATUS_RESET;
      rxData_reg <= TX_RESET;
      rxValid_reg <= 1'b0;
    end else if (clkEn) begin
      spiShift_reg <= spiShift_next;
      txHold_reg <= txHold_next;
      spiCnt_reg <= spiCnt_next;
      spiPending_reg <= spiPending_next;
      spiBit_reg <= spiBit_next;
      spiOe_reg <= spiOe_next;
      i2cState_reg <= i2cState_next;
      phase_reg <= phase_next;
      i2cShift_reg <= i2cShift_next;
      i2cCnt_reg <= i2cCnt_next;
      addr_reg <= addr_next;
      ackOe_reg <= ackOe_next;
      sclHold_reg <= sclHold_next;
      status_reg <= status_next;
      rxData_reg <= rxData_next;
      rxValid_reg <= rxValid_next;
    end
  end

  // Open-drain lines only ever pull low
  assign serialOutPin = spiShift_reg[7]; // R1
  assign serialOutPinOe = spiOe_reg; // R7
  assign serialClockLineOut = 1'b0;
  assign serialClockLineOe = sclHold_reg;
  assign serialDataLineOut = 1'b0;
  assign serialDataLineOe = ackOe_reg;
  assign rxData = rxData_reg;
  assign bufferFullFlag = rxValid_reg;
  assign slaveAddress = addr_reg;
  assign status = status_reg;

endmodule // ssp_slave_top
`default_nettype wire

// ---- ssp_bus_master.sv ----
// Bus master model that drives the SPI and I2C pins of the port
`timescale 1ns/1ps
`default_nettype none
module ssp_bus_master #(
  parameter int SPI_HALF = 40,
  parameter int I2C_HALF = 80
) (
  input wire logic serialOutPin,
  input wire logic serialOutPinOe,
  input wire logic serialClockLineOe,
  input wire logic serialDataLineOe,
  output logic sck,
  output logic selN,
  output logic sdi,
  output logic scl,
  output logic sda
);
  logic sclDrv = 1'b1;
  logic sdaDrv = 1'b1;
  // Open-drain lines with pull-ups: either party may pull low
  assign scl = sclDrv & ~serialClockLineOe;
  assign sda = sdaDrv & ~serialDataLineOe;
  initial begin
    sck = 1'b0;
    selN = 1'b1;
    sdi = 1'b0;
  end
  logic sckIdle = 1'b0;
  task automatic sel(input logic v);
    selN = v;
  endtask
  // Only change the idle level while deselected, or the slave sees an edge
  task automatic setIdle(input logic v);
    sckIdle = v;
    sck = v;
  endtask
  // Slave data is taken just before the next launch: its output lags the clock
  task automatic spiByte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      #(SPI_HALF) sck = ~sckIdle;
      #(SPI_HALF) rx[i] = serialOutPinOe ? serialOutPin : ~serialOutPin;
      sck = sckIdle;
    end
    // Clock stops idle between bytes; old data is not left on the line
    sdi = ~sdi;
  endtask
  task automatic i2cStart();
    sdaDrv = 1'b1;
    sclDrv = 1'b1;
    #(I2C_HALF) sdaDrv = 1'b0;
    #(I2C_HALF) sclDrv = 1'b0;
  endtask
  task automatic i2cStop();
    #(I2C_HALF) sdaDrv = 1'b0;
    #(I2C_HALF) sclDrv = 1'b1;
    #(I2C_HALF) sdaDrv = 1'b1;
    #(I2C_HALF);
  endtask
  // A stretch that never ends yields an unknown sample
  task automatic i2cBit(input logic b, output logic seen);
    int n = 0;
    #(I2C_HALF / 2) sdaDrv = b;
    #(I2C_HALF / 2) sclDrv = 1'b1;
    while (scl !== 1'b1 && n < 400) begin
      #10 n++;
    end
    #(I2C_HALF) seen = (n < 400) ? sda : 1'bx;
    sclDrv = 1'b0;
  endtask
  task automatic i2cByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) i2cBit(b[i], s);
    i2cBit(1'b1, s);
    ack = ~s;
  endtask
endmodule // ssp_bus_master
`default_nettype wire

// ---- ssp_slave_chk.sv ----
// Port checker for the sync serial port slave
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_chk
  import ssp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire ssp_ctrl_s ctrl,
  input wire logic slaveSelectPin_n,
  input wire logic serialOutPinOe,
  input wire logic serialClockLineOe,
  input wire logic serialDataLineOe,
  input wire logic [7:0] addrWriteData,
  input wire logic addrWrite,
  input wire logic clockReleaseSet,
  input wire logic bufferFullFlag,
  input wire logic [7:0] slaveAddress,
  input wire ssp_status_s status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_quiet_unselected: assert property (slaveSelectPin_n [*8] |-> !serialOutPinOe)
    else $error("serial out driven while deselected");
  a_addr_refused_ack: assert property (addrWrite && serialDataLineOe |=> $stable(slaveAddress))
    else $error("address changed during acknowledge");
  a_addr_write_load: assert property (addrWrite && !serialDataLineOe
    |=> slaveAddress == $past(addrWriteData) && status.clockReleaseBit)
    else $error("address write not taken");
  a_release_frees_scl: assert property (clockReleaseSet && serialClockLineOe && !bufferFullFlag
    |-> ##[1:3] !serialClockLineOe)
    else $error("clock not released");
  a_full_raises_irq: assert property ($rose(bufferFullFlag) |-> ##[0:40] status.portInterruptFlag)
    else $error("byte stored without interrupt");
  a_start_irq_on: assert property ($rose(status.startSeen) && ctrl.startIrqEnable
    |-> ##[0:1] status.portInterruptFlag)
    else $error("start interrupt missing");
  a_start_irq_off: assert property ($rose(status.startSeen) && !ctrl.startIrqEnable
    && !$past(status.portInterruptFlag) |-> !status.portInterruptFlag)
    else $error("start interrupt while disabled");
  a_ack_spans_pulse: assert property ($rose(serialDataLineOe) |-> serialDataLineOe [*6])
    else $error("acknowledge too short");
endmodule // ssp_slave_chk
bind ssp_slave_top ssp_slave_chk chk (.mclk(mclk), .reset_n(reset_n), .ctrl(ctrl),
  .slaveSelectPin_n(slaveSelectPin_n), .serialOutPinOe(serialOutPinOe),
  .serialClockLineOe(serialClockLineOe), .serialDataLineOe(serialDataLineOe),
  .addrWriteData(addrWriteData), .addrWrite(addrWrite), .clockReleaseSet(clockReleaseSet),
  .bufferFullFlag(bufferFullFlag), .slaveAddress(slaveAddress), .status(status));
`default_nettype wire

// ---- ssp_slave_top_tb_top.sv ----
// Testbench of the sync serial port slave
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_top_tb_top
  import ssp_pkg::*;
  ;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  ssp_ctrl_s ctrl = '0;
  logic [7:0] txData = 8'h00;
  logic txLoad = 1'b0;
  logic [7:0] addrWriteData = 8'h00;
  logic addrWrite = 1'b0;
  logic clockReleaseSet = 1'b0;
  logic irqClear = 1'b0;
  logic rxRead = 1'b0;
  logic serialOutPin, serialOutPinOe, serialClockLineOe, serialDataLineOe, bufferFullFlag;
  logic sck, selN, sdi, scl, sda, ack;
  logic [7:0] rxData, slaveAddress, got;
  ssp_status_s status;
  int failures = 0;
  int totalChecks = 0;
  always #5 mclk = ~mclk;
  ssp_slave_top uut (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .ctrl(ctrl),
    .serialClockPin(sck), .slaveSelectPin_n(selN), .serialInPin(sdi),
    .serialOutPin(serialOutPin), .serialOutPinOe(serialOutPinOe), .serialClockLineIn(scl),
    .serialClockLineOut(), .serialClockLineOe(serialClockLineOe), .serialDataLineIn(sda),
    .serialDataLineOut(), .serialDataLineOe(serialDataLineOe), .txData(txData),
    .txLoad(txLoad), .addrWriteData(addrWriteData), .addrWrite(addrWrite),
    .clockReleaseSet(clockReleaseSet), .irqClear(irqClear), .rxRead(rxRead), .rxData(rxData),
    .bufferFullFlag(bufferFullFlag), .slaveAddress(slaveAddress), .status(status));
  ssp_bus_master bm (.serialOutPin(serialOutPin), .serialOutPinOe(serialOutPinOe),
    .serialClockLineOe(serialClockLineOe), .serialDataLineOe(serialDataLineOe), .sck(sck),
    .selN(selN), .sdi(sdi), .scl(scl), .sda(sda));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] exp);
    check(rxData, exp);
    strobe(rxRead);
  endtask
  task automatic wrAddr(input logic [7:0] a);
    addrWriteData = a;
    strobe(addrWrite);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1 reset_n = 1'b1;
    tick(4);
    check(status, STATUS_RESET);
    check(slaveAddress, ADDR_RESET);
    check(bufferFullFlag, 1'b0);
    // Six bytes back to back: four in the FIFO, one in the buffer, one dropped
    ctrl.launchOnIdle = 1'b1;
    txData = 8'hA5;
    strobe(txLoad);
    bm.sel(1'b0);
    tick(10);
    for (int k = 0; k < 6; k++) begin
      txData = 8'hA5 + 8'(17 * k);
      strobe(txLoad);
      bm.spiByte(~(8'hA5 + 8'(17 * k)), got);
      check(got, 8'hA5 + 8'(17 * k));
    end
    tick(10);
    check(status.overflow, 1'b1);
    check(status.portInterruptFlag, 1'b1);
    // A read while the clock enable is low must leave the buffer untouched
    clkEn = 1'b0;
    strobe(rxRead);
    clkEn = 1'b1;
    check(bufferFullFlag, 1'b1);
    for (int k = 0; k < 5; k++) rd(~(8'hA5 + 8'(17 * k)));
    check(bufferFullFlag, 1'b0);
    bm.sel(1'b1);
    tick(10);
    check(serialOutPinOe, 1'b0);
    bm.spiByte(8'h5A, got);
    tick(10);
    check(bufferFullFlag, 1'b0);
    // Clock idling high: launch on the rise, capture on the fall
    ctrl.idleHigh = 1'b1;
    bm.setIdle(1'b1);
    txData = 8'h3C;
    strobe(txLoad);
    bm.sel(1'b0);
    tick(10);
    bm.spiByte(8'hC3, got);
    check(got, 8'h3C);
    tick(10);
    rd(8'hC3);
    bm.sel(1'b1);
    bm.setIdle(1'b0);
    // Ten-bit address with stretching
    ctrl = '0;
    ctrl.i2cMode = 1'b1;
    ctrl.startIrqEnable = 1'b1;
    ctrl.stretchEnable = 1'b1;
    strobe(irqClear);
    wrAddr(8'hF4);
    bm.i2cStart();
    tick(10);
    check(status.startSeen, 1'b1);
    check(status.portInterruptFlag, 1'b1);
    strobe(irqClear);
    bm.i2cByte(8'hF4, ack);
    tick(10);
    check({ack, status.updateAddressFlag, status.portInterruptFlag}, 3'h7);
    check(serialClockLineOe, 1'b1);
    strobe(irqClear);
    rd(8'hF4);
    wrAddr(8'hA5);
    tick(3);
    check(serialClockLineOe, 1'b0);
    fork
      bm.i2cByte(8'hA5, ack);
      begin
        for (int n = 0; n < 300 && !serialDataLineOe; n++) tick(1);
        check(serialDataLineOe, 1'b1);
        wrAddr(8'h11);
      end
    join
    tick(10);
    check(slaveAddress, 8'hA5);
    check({ack, status.updateAddressFlag, bufferFullFlag}, 3'h7);
    rd(8'hA5);
    wrAddr(8'hF4);
    for (int k = 0; k < 2; k++) begin
      ctrl.stretchEnable = (k == 0);
      ctrl.dataHoldEnable = (k == 1);
      strobe(irqClear);
      bm.i2cByte(8'h5A + 8'(k), ack);
      tick(10);
      check({ack, status.portInterruptFlag}, 2'h3);
      check({status.clockReleaseBit, serialClockLineOe}, 2'h1);
      rd(8'h5A + 8'(k));
      strobe(clockReleaseSet);
      tick(3);
      check(serialClockLineOe, 1'b0);
    end
    bm.i2cStop();
    tick(10);
    check(status.stopSeen, 1'b1);
    // Start interrupt off, then a low address that does not match
    ctrl.startIrqEnable = 1'b0;
    strobe(irqClear);
    bm.i2cStart();
    tick(10);
    check(status.portInterruptFlag, 1'b0);
    bm.i2cByte(8'hF4, ack);
    tick(10);
    check(ack, 1'b1);
    rd(8'hF4);
    wrAddr(8'hA5);
    strobe(irqClear);
    bm.i2cByte(8'h33, ack);
    tick(10);
    check({ack, status.updateAddressFlag, status.portInterruptFlag}, 3'h3);
    check({bufferFullFlag, status.clockReleaseBit}, 2'h1);
    wrAddr(8'hF4);
    bm.i2cStop();
    finish_test();
  end
endmodule // ssp_slave_top_tb_top
`default_nettype wire
